// [ohb_host.sv]
`timescale 1ns/1ps
`default_nettype none
module ohb_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic         clk_i,      // clock
	input  wire logic         rst_b_i,    // synchronous reset, active low
	input  wire logic [W-1:0] in_data_i,  // write data
	input  wire logic         in_valid_i, // write offered
	output logic              in_ready_o, // room available
	output logic [W-1:0]      out_data_o, // head word
	output logic              out_valid_o,// head valid
	input  wire logic         out_ready_i // head taken
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} ohb_fifo_t;

	ohb_fifo_t q;
	ohb_fifo_t next_q;
	logic [W-1:0] mem [DEPTH];
	logic full, empty;

	// extra pointer bit separates full from empty
	assign empty = q.wp == q.rp;
	assign full  = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = mem[q.rp[AW-1:0]];

	always_comb begin
		next_q = q;
		if (in_valid_i && !full) begin
			next_q.wp = q.wp + 1'b1;
		end
		if (out_ready_i && !empty) begin
			next_q.rp = q.rp + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (in_valid_i && !full) begin
			mem[q.wp[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
endmodule : ohb_fifo

module ohb_host
	import ohb_pkg::*;
#(
	parameter int unsigned ON_DELAY = ON_DELAY_CYC, // wait after clearing, in cycles
	parameter int unsigned CLEAR_N  = CLEAR_BYTES   // bytes written to clear memory
) (
	input  wire logic       clk_i,       // 100 MHz clock
	input  wire logic       rst_b_i,     // synchronous reset, active low
	input  wire logic [1:0] mode_i,      // {hi, lo} interface select
	ohb_link_if.host        lnk,         // device pins
	input  wire logic [7:0] pix_data_i,  // pixel byte
	input  wire logic       pix_valid_i, // pixel offered
	output logic            pix_ready_o, // fifo has room
	input  wire logic       rd_req_i,    // read request (parallel only)
	input  wire logic       rd_dc_i,     // dc level for the read
	output logic            rd_ready_o,  // read request taken
	output logic [7:0]      rd_data_o,   // read result
	output logic            rd_valid_o,  // one-cycle pulse: read result
	output logic            init_done_o  // sequence done, streaming
);
	typedef enum {H_RESET_LO, H_RESET_HI, H_INIT, H_CLEAR, H_WAIT, H_ON, H_WIN, H_RUN} ohb_hst_t;
	typedef enum {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD, PH_SCLK_LO, PH_SCLK_HI} ohb_ph_t;
	typedef struct packed {
		ohb_hst_t    hst;
		ohb_ph_t     ph;
		logic [24:0] cnt;
		logic [5:0]  idx;
		logic [13:0] nclr;
		logic [3:0]  tcnt;
		logic [3:0]  nbit;
		logic [8:0]  sh;
		logic        xrd;
		logic [7:0]  xbyte;
		logic [7:0]  bus_s1;
		logic [7:0]  bus_s2;
		logic [7:0]  rd_data;
		logic        rd_valid;
		logic        res_n;
		logic [1:0]  mode;
		logic        cs_n;
		logic        dc;
		logic        en_rd;
		logic        dir_wr;
		logic        sclk;
		logic        init_done;
	} ohb_host_t;

	ohb_host_t q;
	ohb_host_t next_q;
	logic [7:0] f_data;
	logic f_valid, f_ready;
	logic go, go_rd;
	logic [8:0] go_w;
	logic par;
	ohb_mode_t mode;

	// every entry is {dc, byte}: commands dc low, arguments dc high
	function automatic logic [8:0] rom(input logic [5:0] i);
		unique case (i)
			6'd0: rom = 9'h0FD; 6'd1: rom = 9'h112; 6'd2: rom = 9'h0AE;
			6'd3: rom = 9'h0B4; 6'd4: rom = 9'h1A0; 6'd5: rom = 9'h1B5;
			6'd6: rom = 9'h0A0; 6'd7: rom = 9'h110; 6'd8: rom = 9'h111;
			6'd9: rom = 9'h0CA; 6'd10: rom = 9'h13F;
			6'd11: rom = 9'h0D1; 6'd12: rom = 9'h182; 6'd13: rom = 9'h120;
			6'd14: rom = 9'h0C1; 6'd15: rom = 9'h17D; 6'd16: rom = 9'h0C7; 6'd17: rom = 9'h10F;
			6'd18: rom = 9'h0B3; 6'd19: rom = 9'h191;
			6'd20: rom = 9'h0B1; 6'd21: rom = 9'h1F8;
			6'd22: rom = 9'h0BB; 6'd23: rom = 9'h10F; 6'd24: rom = 9'h0BE; 6'd25: rom = 9'h107;
			6'd26: rom = 9'h0B6; 6'd27: rom = 9'h10F;
			6'd28: rom = 9'h0AB; 6'd29: rom = 9'h101; 6'd30: rom = 9'h0B8;
			6'd31: rom = 9'h100; 6'd32: rom = 9'h100; 6'd33: rom = 9'h100; 6'd34: rom = 9'h103;
			6'd35: rom = 9'h106; 6'd36: rom = 9'h10F; 6'd37: rom = 9'h11D; 6'd38: rom = 9'h12A;
			6'd39: rom = 9'h137; 6'd40: rom = 9'h146; 6'd41: rom = 9'h158; 6'd42: rom = 9'h16A;
			6'd43: rom = 9'h17F; 6'd44: rom = 9'h196; 6'd45: rom = 9'h1B4;
			6'd46: rom = 9'h000;
			6'd47: rom = 9'h0A1; 6'd48: rom = 9'h100; 6'd49: rom = 9'h0A2; 6'd50: rom = 9'h100;
			6'd51: rom = 9'h0A6;
			6'd52: rom = 9'h015; 6'd53: rom = 9'h11C; 6'd54: rom = 9'h1B5;
			6'd55: rom = 9'h075; 6'd56: rom = 9'h100; 6'd57: rom = 9'h13F;
			default: rom = 9'h05C;
		endcase
	endfunction

	ohb_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i      (clk_i),
		.rst_b_i    (rst_b_i),
		.in_data_i  (pix_data_i),
		.in_valid_i (pix_valid_i),
		.in_ready_o (pix_ready_o),
		.out_data_o (f_data),
		.out_valid_o(f_valid),
		.out_ready_i(f_ready)
	);

	assign mode = ohb_mode_t'(q.mode);
	assign par  = q.mode[1];

	// pick the next transfer; reads refused in serial modes since there is no return line
	always_comb begin
		go = 1'b0;
		go_rd = 1'b0;
		go_w = 9'h000;
		f_ready = 1'b0;
		rd_ready_o = 1'b0;
		if (q.ph == PH_IDLE) begin
			unique case (q.hst)
				H_INIT, H_WIN: begin
					go = 1'b1;
					go_w = rom(q.idx);
				end
				H_CLEAR: begin
					go = 1'b1;
					go_w = {1'b1, CLEAR_FILL};
				end
				H_ON: begin
					go = 1'b1;
					go_w = {1'b0, CMD_DISP_ON};
				end
				H_RUN: begin
					if (rd_req_i && par) begin
						go = 1'b1;
						go_rd = 1'b1;
						go_w = {rd_dc_i, 8'h00};
						rd_ready_o = 1'b1;
					end else if (f_valid) begin
						go = 1'b1;
						go_w = {1'b1, f_data};
						f_ready = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		next_q = q;
		next_q.bus_s1 = lnk.host_bus;
		next_q.bus_s2 = q.bus_s1;
		next_q.rd_valid = 1'b0;
		// sequence walker
		unique case (q.hst)
			H_RESET_LO: begin
				next_q.mode = mode_i;
				// separate strobes idle high, else the first select would meet a rising write strobe
				next_q.en_rd = ohb_mode_t'(mode_i) == MODE_SEP;
				next_q.dir_wr = ohb_mode_t'(mode_i) == MODE_SEP;
				next_q.cnt = q.cnt + 25'h1;
				if (q.cnt == 25'(RES_CYC - 1)) begin
					next_q.hst = H_RESET_HI;
					next_q.res_n = 1'b1;
					next_q.cnt = 25'h0;
				end
			end
			H_RESET_HI: begin
				next_q.cnt = q.cnt + 25'h1;
				if (q.cnt == 25'(RES_CYC - 1)) begin
					next_q.hst = H_INIT;
				end
			end
			H_INIT, H_WIN: begin
				if (go) begin
					next_q.idx = q.idx + 6'h1;
					if (q.idx == 6'(ROM_LEN - 1)) begin
						next_q.hst = (q.hst == H_INIT) ? H_CLEAR : H_RUN;
						next_q.init_done = q.hst == H_WIN;
					end
				end
			end
			H_CLEAR: begin
				if (go) begin
					next_q.nclr = q.nclr + 14'h1;
					if (q.nclr == 14'(CLEAR_N - 1)) begin
						next_q.hst = H_WAIT;
						next_q.cnt = 25'h0;
					end
				end
			end
			H_WAIT: begin
				// the last clear byte must leave the pins before the wait counts
				if (q.ph == PH_IDLE) begin
					next_q.cnt = q.cnt + 25'h1;
					if (q.cnt == 25'(ON_DELAY - 1)) begin
						next_q.hst = H_ON;
					end
				end
			end
			H_ON: begin
				if (go) begin
					next_q.hst = H_WIN;
					next_q.idx = 6'(IDX_WIN);
				end
			end
			H_RUN: begin
			end
		endcase
		// pin engine
		unique case (q.ph)
			PH_IDLE: begin
				if (go) begin
					next_q.ph = PH_SETUP;
					next_q.cs_n = 1'b0;
					next_q.dc = go_w[8];
					next_q.xbyte = go_w[7:0];
					next_q.xrd = go_rd;
					next_q.tcnt = 4'h0;
					next_q.dir_wr = (mode == MODE_ENABLE) ? go_rd : par;
					next_q.sh = (mode == MODE_SPI3) ? go_w : {go_w[7:0], 1'b0};
					next_q.nbit = (mode == MODE_SPI3) ? 4'(SER3_BITS) : 4'(SER4_BITS);
				end
			end
			PH_SETUP: begin
				next_q.tcnt = 4'h0;
				if (mode == MODE_ENABLE) begin
					next_q.ph = PH_STROBE;
					next_q.en_rd = 1'b1;
				end else if (mode == MODE_SEP) begin
					next_q.ph = PH_STROBE;
					next_q.en_rd = !q.xrd;
					next_q.dir_wr = q.xrd;
				end else begin
					next_q.ph = PH_SCLK_LO;
				end
			end
			PH_STROBE: begin
				next_q.tcnt = q.tcnt + 4'h1;
				if (q.tcnt == 4'(STROBE_CYC - 1)) begin
					next_q.ph = PH_HOLD;
					next_q.en_rd = mode == MODE_SEP;
					next_q.dir_wr = (mode == MODE_SEP) ? 1'b1 : q.dir_wr;
					if (q.xrd) begin
						next_q.rd_data = q.bus_s2;
						next_q.rd_valid = 1'b1;
					end
				end
			end
			PH_HOLD: begin
				next_q.cs_n = 1'b1;
				next_q.ph = PH_IDLE;
			end
			PH_SCLK_LO: begin
				next_q.tcnt = q.tcnt + 4'h1;
				if (q.tcnt == 4'(SCLK_HALF_CYC - 1)) begin
					next_q.ph = PH_SCLK_HI;
					next_q.sclk = 1'b1;
					next_q.tcnt = 4'h0;
				end
			end
			PH_SCLK_HI: begin
				next_q.tcnt = q.tcnt + 4'h1;
				if (q.tcnt == 4'(SCLK_HALF_CYC - 1)) begin
					next_q.sclk = 1'b0;
					next_q.tcnt = 4'h0;
					next_q.sh = {q.sh[7:0], 1'b0};
					next_q.nbit = q.nbit - 4'h1;
					next_q.ph = (q.nbit == 4'h1) ? PH_HOLD : PH_SCLK_LO;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q <= '{hst: H_RESET_LO, ph: PH_IDLE, cnt: 25'h0, idx: 6'h0, nclr: 14'h0, tcnt: 4'h0,
				nbit: 4'h0, sh: 9'h000, xrd: 1'b0, xbyte: 8'h00, bus_s1: 8'h00, bus_s2: 8'h00,
				rd_data: 8'h00, rd_valid: 1'b0, res_n: 1'b0, mode: 2'h0, cs_n: 1'b1, dc: 1'b0,
				en_rd: 1'b0, dir_wr: 1'b0, sclk: 1'b0, init_done: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	// pins; unused lines driven low in serial mode, line two included, while the reset pin is released
	assign lnk.reset_n_input   = q.res_n;
	assign lnk.iface_select_lo = q.mode[0];
	assign lnk.iface_select_hi = q.mode[1];
	assign lnk.cs_n            = q.cs_n;
	assign lnk.dc              = q.dc;
	assign lnk.en_rd           = q.en_rd;
	assign lnk.dir_wr          = q.dir_wr;
	assign lnk.host_bus_o      = par ? q.xbyte : {6'h00, q.sh[8], q.sclk};
	assign lnk.host_bus_oe     = par ? (!q.cs_n && !q.xrd) : q.res_n;
	assign rd_data_o           = q.rd_data;
	assign rd_valid_o          = q.rd_valid;
	assign init_done_o         = q.init_done;
endmodule : ohb_host
`default_nettype wire

// [ohb_pkg.sv]
package ohb_pkg;
	localparam int CLK_NS        = 10;
	localparam int T_STROBE_NS   = 80;
	localparam int STROBE_CYC    = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_SCLK_HALF_NS = 50;
	localparam int SCLK_HALF_CYC = (T_SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RES_NS      = 10000;
	localparam int RES_CYC       = (T_RES_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_ON_DELAY_MS = 200;
	localparam int ON_DELAY_CYC  = T_ON_DELAY_MS * (1000000 / CLK_NS);
	localparam int CLEAR_BYTES   = 8192;
	localparam int FIFO_W        = 8;
	localparam int FIFO_DEPTH    = 8;
	localparam int ROM_LEN       = 59;
	localparam int IDX_WIN       = 52;
	localparam int SER3_BITS     = 9;
	localparam int SER4_BITS     = 8;
	localparam logic [7:0] CMD_DISP_ON = 8'hAF;
	localparam logic [7:0] CLEAR_FILL  = 8'h00;

	// interface select pins as {iface_select_hi, iface_select_lo}
	typedef enum logic [1:0] {
		MODE_SPI4   = 2'h0,
		MODE_SPI3   = 2'h1,
		MODE_SEP    = 2'h2,
		MODE_ENABLE = 2'h3
	} ohb_mode_t;
endpackage : ohb_pkg

// [ohb_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ohb_link_if;
	logic       reset_n_input;   // device reset, active low
	logic       iface_select_lo; // mode select low bit
	logic       iface_select_hi; // mode select high bit
	logic       cs_n;            // chip select, active low
	logic       dc;              // high data, low command
	logic       en_rd;           // enable strobe or read strobe (low)
	logic       dir_wr;          // direction or write strobe (low)
	logic [7:0] host_bus_o;      // host drive value
	logic       host_bus_oe;     // host drives bus
	logic [7:0] dev_bus_o;       // device drive value
	logic       dev_bus_oe;      // device drives bus
	logic [7:0] host_bus;        // resolved bus level

	// undriven lines settle low, as grounded lines would
	assign host_bus = host_bus_oe ? host_bus_o : (dev_bus_oe ? dev_bus_o : 8'h00);

	modport host (output reset_n_input, iface_select_lo, iface_select_hi, cs_n, dc, en_rd, dir_wr,
		host_bus_o, host_bus_oe, input host_bus);
	modport dev (input reset_n_input, iface_select_lo, iface_select_hi, cs_n, dc, en_rd, dir_wr,
		host_bus, output dev_bus_o, dev_bus_oe);
endinterface : ohb_link_if
`default_nettype wire

// [ohb_device.sv]
`timescale 1ns/1ps
`default_nettype none
module ohb_device
	import ohb_pkg::*;
(
	input  wire logic       clk_i,        // 100 MHz clock
	input  wire logic       rst_b_i,      // synchronous reset, active low
	ohb_link_if.dev         lnk,          // host-facing pins
	output logic            wr_valid_o,   // one-cycle pulse: byte received
	output logic [7:0]      wr_data_o,    // received byte
	output logic            wr_is_data_o, // 1 display data, 0 command
	output logic            rd_req_o,     // one-cycle pulse: host read begins
	input  wire logic [7:0] rd_byte_i,    // byte returned on reads
	output logic            in_reset_o    // internal initialisation running
);
	// pin order in sync vector: {res_n, sel_hi, sel_lo, cs_n, dc, en_rd, dir_wr, bus}
	typedef struct packed {
		logic [14:0] s1;
		logic [14:0] s2;
		logic        en_prev;
		logic        wr_prev;
		logic        sclk_prev;
		logic [8:0]  sh;
		logic [3:0]  nbit;
		logic [7:0]  wr_data;
		logic        wr_dc;
		logic        wr_valid;
		logic        rd_req;
		logic [7:0]  drv;
		logic        in_reset;
	} ohb_dev_t;

	ohb_dev_t q;
	ohb_dev_t next_q;
	ohb_mode_t mode;
	logic cs_n, dc, en, wr, sclk, serial_data_in, res_n;

	// only the second stage is ever decoded
	assign res_n = q.s2[14];
	assign mode  = ohb_mode_t'(q.s2[13:12]);
	assign cs_n  = q.s2[11];
	assign dc    = q.s2[10];
	assign en    = q.s2[9];
	assign wr    = q.s2[8];
	assign sclk  = q.s2[0];
	assign serial_data_in  = q.s2[1];

	// read drive: enable high with direction high, or read strobe low
	always_comb begin
		lnk.dev_bus_oe = 1'b0;
		if (!cs_n && !q.in_reset) begin
			if (mode == MODE_ENABLE) begin
				lnk.dev_bus_oe = en && wr;
			end else if (mode == MODE_SEP) begin
				lnk.dev_bus_oe = !en;
			end
		end
	end
	assign lnk.dev_bus_o = q.drv;

	always_comb begin
		next_q = q;
		next_q.s1 = {lnk.reset_n_input, lnk.iface_select_hi, lnk.iface_select_lo, lnk.cs_n, lnk.dc,
			lnk.en_rd, lnk.dir_wr, lnk.host_bus};
		next_q.s2 = q.s1;
		next_q.en_prev = en;
		next_q.wr_prev = wr;
		next_q.sclk_prev = sclk;
		next_q.wr_valid = 1'b0;
		next_q.rd_req = 1'b0;
		next_q.drv = rd_byte_i;
		next_q.in_reset = !res_n;
		if (!res_n) begin
			next_q.nbit = 4'h0;
			next_q.sh = 9'h000;
		end else if (cs_n) begin
			next_q.nbit = 4'h0;
		end else begin
			unique case (mode)
				MODE_ENABLE: begin
					// read starts on the rising enable, write lands on its falling edge
					if (en && !q.en_prev && wr) begin
						next_q.rd_req = 1'b1;
					end
					if (!en && q.en_prev && !wr) begin
						next_q.wr_valid = 1'b1;
						next_q.wr_data = q.s2[7:0];
						next_q.wr_dc = dc;
					end
				end
				MODE_SEP: begin
					if (!en && q.en_prev) begin
						next_q.rd_req = 1'b1;
					end
					// data is still held when the write strobe returns high
					if (wr && !q.wr_prev) begin
						next_q.wr_valid = 1'b1;
						next_q.wr_data = q.s2[7:0];
						next_q.wr_dc = dc;
					end
				end
				default: begin
					// serial: shift on the rising clock, first bit is the msb
					if (sclk && !q.sclk_prev) begin
						next_q.sh = {q.sh[7:0], serial_data_in};
						next_q.nbit = q.nbit + 4'h1;
						if (mode == MODE_SPI3 && q.nbit == 4'(SER3_BITS - 1)) begin
							next_q.wr_valid = 1'b1;
							next_q.wr_data = {q.sh[6:0], serial_data_in};
							next_q.wr_dc = q.sh[7];
							next_q.nbit = 4'h0;
						end else if (mode == MODE_SPI4 && q.nbit == 4'(SER4_BITS - 1)) begin
							next_q.wr_valid = 1'b1;
							next_q.wr_data = {q.sh[6:0], serial_data_in};
							next_q.wr_dc = dc;
							next_q.nbit = 4'h0;
						end
					end
				end
			endcase
		end
	end

	// reset value shows the reset pin low, so the device cannot leave reset before the real pin is synced
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			q <= '{s1: 15'h3FFF, s2: 15'h3FFF, en_prev: 1'b0, wr_prev: 1'b1, sclk_prev: 1'b0,
				sh: 9'h000, nbit: 4'h0, wr_data: 8'h00, wr_dc: 1'b0, wr_valid: 1'b0, rd_req: 1'b0,
				drv: 8'h00, in_reset: 1'b1};
		end else begin
			q <= next_q;
		end
	end

	assign wr_valid_o   = q.wr_valid;
	assign wr_data_o    = q.wr_data;
	assign wr_is_data_o = q.wr_dc;
	assign rd_req_o     = q.rd_req;
	assign in_reset_o   = q.in_reset;
endmodule : ohb_device
`default_nettype wire

// [ohb_link_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module ohb_link_sva
	import ohb_pkg::*;
(
	input wire logic       clk_i,           // link clock
	input wire logic       rst_b_i,         // synchronous reset, active low
	input wire logic       reset_n_input,   // device reset pin
	input wire logic       iface_select_lo, // mode select low bit
	input wire logic       iface_select_hi, // mode select high bit
	input wire logic       cs_n,            // chip select, active low
	input wire logic       dc,              // data or command
	input wire logic       en_rd,           // enable or read strobe
	input wire logic       dir_wr,          // direction or write strobe
	input wire logic       host_bus_oe,     // host drives bus
	input wire logic       dev_bus_oe,      // device drives bus
	input wire logic [7:0] host_bus         // resolved bus
);
	logic [1:0]  mode;
	int unsigned low_cnt;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	assign mode = {iface_select_hi, iface_select_lo};

	// length of the device reset pulse, so its width can be held to a figure
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || reset_n_input)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end

	// strobe and serial clock phases
	sequence s_strobe_on;
		en_rd [*8];
	endsequence
	sequence s_sclk_high;
		host_bus[0] [*5];
	endsequence

	chk_reset_pin_idle: assert property ($rose(rst_b_i) |-> !reset_n_input && cs_n)
		else $error("device reset or select not idle after reset");
	chk_reset_pulse_len: assert property ($rose(reset_n_input) |-> low_cnt inside {[RES_CYC-1:RES_CYC+1]})
		else $error("device reset pulse has wrong width");
	chk_enable_strobe_len: assert property ($rose(en_rd) && mode == MODE_ENABLE |-> s_strobe_on ##1 !en_rd)
		else $error("enable strobe width wrong");
	chk_enable_dir_bus: assert property (mode == MODE_ENABLE && en_rd |-> !cs_n && (host_bus_oe == !dir_wr))
		else $error("enable strobe without select or wrong bus direction");
	chk_sep_write_drive: assert property (mode == MODE_SEP && reset_n_input && !dir_wr |-> !cs_n && host_bus_oe)
		else $error("write strobe without select or host drive");
	chk_sep_read_release: assert property (mode == MODE_SEP && reset_n_input && !en_rd |-> !cs_n && !host_bus_oe)
		else $error("read strobe without select or host still driving");
	chk_serial_strobes_low: assert property (!mode[1] && reset_n_input |-> !en_rd && !dir_wr)
		else $error("strobe inputs not grounded in serial mode");
	chk_sclk_half_len: assert property (!mode[1] && $rose(host_bus[0]) |-> s_sclk_high ##1 !host_bus[0])
		else $error("serial clock high phase wrong");
	chk_serial_unused_lines: assert property (!mode[1] && !cs_n |-> host_bus[7:3] == 5'h00)
		else $error("unused bus lines not low in serial mode");
	chk_dev_drive_release: assert property ($rose(cs_n) |-> ##3 !dev_bus_oe)
		else $error("device still drives bus after deselect");
endmodule : ohb_link_sva
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ohb_pkg::*;
	localparam int unsigned ON_D  = 50;
	localparam int unsigned CLR_N = 4;
	localparam logic [8:0] ROM [ROM_LEN] = '{
		9'h0FD, 9'h112, 9'h0AE, 9'h0B4, 9'h1A0, 9'h1B5, 9'h0A0, 9'h110, 9'h111, 9'h0CA, 9'h13F, 9'h0D1,
		9'h182, 9'h120, 9'h0C1, 9'h17D, 9'h0C7, 9'h10F, 9'h0B3, 9'h191, 9'h0B1, 9'h1F8, 9'h0BB, 9'h10F,
		9'h0BE, 9'h107, 9'h0B6, 9'h10F, 9'h0AB, 9'h101, 9'h0B8, 9'h100, 9'h100, 9'h100, 9'h103, 9'h106,
		9'h10F, 9'h11D, 9'h12A, 9'h137, 9'h146, 9'h158, 9'h16A, 9'h17F, 9'h196, 9'h1B4, 9'h000, 9'h0A1,
		9'h100, 9'h0A2, 9'h100, 9'h0A6, 9'h015, 9'h11C, 9'h1B5, 9'h075, 9'h100, 9'h13F, 9'h05C};
	logic       clk_i;
	logic       rst_b_i;
	logic [1:0] mode_i;
	logic [7:0] pix_data_i;
	logic       pix_valid_i;
	logic       pix_ready_o;
	logic       rd_req_i;
	logic       rd_dc_i;
	logic       rd_ready_o;
	logic [7:0] rd_data_o;
	logic       rd_valid_o;
	logic       init_done_o;
	logic       wr_valid_o;
	logic [7:0] wr_data_o;
	logic       wr_is_data_o;
	logic       rd_req_o;
	logic [7:0] rd_byte_i;
	logic       in_reset_o;
	int         fails;
	int         num_checks;
	int         cyc;
	int         prev;
	int         on_gap;
	int         n_rdreq;
	logic [8:0] exp_q [$];
	logic [8:0] got_q [$];

	ohb_link_if lnk();
	ohb_host #(.ON_DELAY(ON_D), .CLEAR_N(CLR_N)) ohb_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .mode_i(mode_i),
		.lnk(lnk), .pix_data_i(pix_data_i), .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
		.rd_req_i(rd_req_i), .rd_dc_i(rd_dc_i), .rd_ready_o(rd_ready_o), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .init_done_o(init_done_o));
	ohb_device ohb_device_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .lnk(lnk), .wr_valid_o(wr_valid_o),
		.wr_data_o(wr_data_o), .wr_is_data_o(wr_is_data_o), .rd_req_o(rd_req_o), .rd_byte_i(rd_byte_i),
		.in_reset_o(in_reset_o));
	ohb_link_sva ohb_link_sva_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .reset_n_input(lnk.reset_n_input),
		.iface_select_lo(lnk.iface_select_lo), .iface_select_hi(lnk.iface_select_hi), .cs_n(lnk.cs_n),
		.dc(lnk.dc), .en_rd(lnk.en_rd), .dir_wr(lnk.dir_wr), .host_bus_oe(lnk.host_bus_oe),
		.dev_bus_oe(lnk.dev_bus_oe), .host_bus(lnk.host_bus));

	// free-running clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// collect every byte the device takes in, and time the gap before display-on
	always @(posedge clk_i) begin
		cyc++;
		if (rd_req_o === 1'b1)
			n_rdreq++;
		if (wr_valid_o === 1'b1) begin
			got_q.push_back({wr_is_data_o, wr_data_o});
			if ({wr_is_data_o, wr_data_o} === 9'h0AF)
				on_gap = cyc - prev;
			prev = cyc;
		end
	end

	task automatic check(input logic c, input string msg);
		num_checks++;
		if (c !== 1'b1) begin
			fails++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// hold the request until it is taken, then wait for the result pulse
	task automatic do_read(input logic d, input logic [7:0] b);
		int n;
		int r0;
		#1 rd_byte_i = b;
		rd_dc_i = d;
		rd_req_i = 1'b1;
		n = 0;
		r0 = n_rdreq;
		do begin
			@(posedge clk_i);
			n++;
		end while (rd_ready_o !== 1'b1 && n < 100);
		check(rd_ready_o === 1'b1, "read request not taken");
		#1 rd_req_i = 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (rd_valid_o !== 1'b1 && n < 100);
		check(rd_valid_o === 1'b1, "read result missing");
		check(rd_data_o === b, "read data wrong");
		check(n_rdreq == r0 + 1, "device read start not seen");
	endtask

	task automatic run_mode(input logic [1:0] m);
		int acc;
		int n;
		#1 mode_i = m;
		rst_b_i = 1'b0;
		repeat (5) @(posedge clk_i);
		#1 rst_b_i = 1'b1;
		got_q.delete();
		// a stale gap from the previous mode must not satisfy this mode's check
		on_gap = 0;
		// nothing drains the fifo before init ends, so it must refuse after its depth
		acc = 0;
		pix_data_i = 8'h00;
		pix_valid_i = 1'b1;
		repeat (20) begin
			@(posedge clk_i);
			if (pix_ready_o === 1'b1)
				acc++;
			#1 pix_data_i = acc[7:0];
		end
		pix_valid_i = 1'b0;
		check(acc == FIFO_DEPTH, "fifo depth wrong");
		check(in_reset_o === 1'b1, "device not in reset");
		n = 0;
		while ((init_done_o !== 1'b1 || got_q.size() < exp_q.size()) && n < 30000) begin
			@(posedge clk_i);
			n++;
		end
		check(got_q.size() == exp_q.size(), "byte count wrong");
		foreach (exp_q[i])
			if (i < got_q.size())
				check(got_q[i] === exp_q[i], $sformatf("byte %0d mode %0d", i, m));
		check(on_gap >= ON_D, "display-on too early");
		check(in_reset_o === 1'b0, "device still in reset");
		check(init_done_o === 1'b1, "init sequence not done");
		check({lnk.iface_select_hi, lnk.iface_select_lo} === m, "mode pins wrong");
		if (m[1]) begin
			do_read(1'b0, 8'hA5 ^ {6'h00, m});
			do_read(1'b1, 8'h3C);
		end else begin
			#1 rd_req_i = 1'b1;
			repeat (30) begin
				@(posedge clk_i);
				check(rd_ready_o === 1'b0, "serial read accepted");
			end
			#1 rd_req_i = 1'b0;
		end
	endtask

	// stop a hung run
	initial begin
		repeat (100000) @(posedge clk_i);
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end

	// main sequence: each interface mode runs init and streaming; parallel modes also run reads, serial modes check reads are refused
	initial begin
		rst_b_i = 1'b0;
		mode_i = 2'h3;
		pix_valid_i = 1'b0;
		pix_data_i = 8'h00;
		rd_req_i = 1'b0;
		rd_dc_i = 1'b0;
		rd_byte_i = 8'h00;
		{fails, num_checks, cyc, prev, on_gap, n_rdreq} = '0;
		foreach (ROM[i])
			exp_q.push_back(ROM[i]);
		repeat (CLR_N) exp_q.push_back(9'h100);
		exp_q.push_back(9'h0AF);
		for (int i = IDX_WIN; i < ROM_LEN; i++)
			exp_q.push_back(ROM[i]);
		for (int i = 0; i < FIFO_DEPTH; i++)
			exp_q.push_back(9'h100 + 9'(i));
		for (int m = 3; m >= 0; m--)
			run_mode(m[1:0]);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
